// ===== cie_pkg.sv
`default_nettype none
package cie_pkg;

  // ==========================================================================
  // Timing and sizes
  // ==========================================================================
  // Core clocks per instruction cycle.
  localparam int          CYCLE_CLKS  = 4;
  localparam int          STACK_DEPTH = 8;
  localparam int          SP_W        = $clog2(STACK_DEPTH);

  // ==========================================================================
  // Register map (byte addresses) and field positions
  // ==========================================================================
  localparam logic [7:0]  REG_CTRL    = 8'h00;
  localparam logic [7:0]  REG_WORK    = 8'h04;
  localparam logic [7:0]  REG_STATUS  = 8'h08;
  localparam logic [7:0]  REG_PC      = 8'h0C;
  localparam logic [7:0]  REG_PAGE    = 8'h10;
  localparam logic [7:0]  REG_WDT     = 8'h14;
  localparam int          CTRL_RUN    = 0;
  localparam int          ST_C        = 0;
  localparam int          ST_HC       = 1;
  localparam int          ST_Z        = 2;
  localparam int          ST_PDN      = 3;
  localparam int          ST_TMO      = 4;
  localparam logic        RST_RUN     = 1'b0;
  localparam logic        RST_STFLAG  = 1'b1;

  // ==========================================================================
  // Instruction encodings
  // ==========================================================================
  localparam logic [13:0] ENC_WDT_CLR = 14'h0064;
  localparam logic [5:0]  ENC_ADD_F   = 6'h07;
  localparam logic [5:0]  ENC_AND_F   = 6'h05;
  localparam logic [5:0]  ENC_OR_F    = 6'h04;
  localparam logic [5:0]  ENC_COMP_F  = 6'h09;
  localparam logic [5:0]  ENC_CLR     = 6'h01;
  localparam logic [5:0]  ENC_DEC_F   = 6'h03;
  localparam logic [5:0]  ENC_INC_F   = 6'h0A;
  localparam logic [5:0]  ENC_DEC_SK  = 6'h0B;
  localparam logic [5:0]  ENC_INC_SK  = 6'h0F;
  localparam logic [5:0]  ENC_AND_L   = 6'h39;
  localparam logic [5:0]  ENC_OR_L    = 6'h38;
  localparam logic [4:0]  ENC_ADD_L   = 5'h1F;
  localparam logic [3:0]  ENC_BIT_SET = 4'h5;
  localparam logic [3:0]  ENC_SK_CLR  = 4'h6;
  localparam logic [3:0]  ENC_SK_SET  = 4'h7;
  localparam logic [2:0]  ENC_CALL    = 3'h4;
  localparam logic [2:0]  ENC_BRANCH  = 3'h5;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [1:0] {
    PH_ADDR  = 2'b00,
    PH_LATCH = 2'b01,
    PH_EXEC  = 2'b10,
    PH_WRITE = 2'b11
  } cie_phase_t;

  typedef enum logic [4:0] {
    OP_NOP      = 5'b00000, OP_ADD_FILE = 5'b00001, OP_AND_FILE = 5'b00010,
    OP_OR_FILE  = 5'b00011, OP_COMP     = 5'b00100, OP_CLR_FILE = 5'b00101,
    OP_CLR_W    = 5'b00110, OP_DEC      = 5'b00111, OP_INC      = 5'b01000,
    OP_DEC_SKIP = 5'b01001, OP_INC_SKIP = 5'b01010, OP_BIT_SET  = 5'b01011,
    OP_SKIP_CLR = 5'b01100, OP_SKIP_SET = 5'b01101, OP_CALL     = 5'b01110,
    OP_BRANCH   = 5'b01111, OP_AND_LIT  = 5'b10000, OP_OR_LIT   = 5'b10001,
    OP_ADD_LIT  = 5'b10010, OP_WDT_CLR  = 5'b10011
  } cie_op_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } cie_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } cie_apb_rsp_t;

  typedef struct packed {
    logic [6:0]  addr;
    logic        we;
    logic [7:0]  wdata;
  } cie_file_req_t;

  typedef struct packed {
    logic                       run;
    cie_phase_t                 phase;
    logic [12:0]                pc;
    logic [13:0]                inst;
    logic                       discard;
    logic                       hold;
    logic [7:0]                 wreg;
    logic                       carry;
    logic                       half_carry;
    logic                       zero;
    logic                       pdown_flag;
    logic                       timeout_flag;
    logic [7:0]                 page;
    logic [7:0]                 wdt_cnt;
    logic [7:0]                 wdt_pre;
    logic [STACK_DEPTH-1:0][12:0] stack;
    logic [SP_W-1:0]            sp;
    logic                       file_we;
    logic [7:0]                 file_wdata;
    logic [31:0]                prdata;
    logic                       pslverr;
  } cie_state_t;

  // Decode one instruction word; anything unknown runs as a no-operation.
  function automatic cie_op_t cie_decode(input logic [13:0] w);
    cie_op_t o;
    o = OP_NOP;
    if (w == ENC_WDT_CLR) o = OP_WDT_CLR;
    else if (w[13:11] == ENC_CALL) o = OP_CALL;
    else if (w[13:11] == ENC_BRANCH) o = OP_BRANCH;
    else if (w[13:10] == ENC_BIT_SET) o = OP_BIT_SET;
    else if (w[13:10] == ENC_SK_CLR) o = OP_SKIP_CLR;
    else if (w[13:10] == ENC_SK_SET) o = OP_SKIP_SET;
    else if (w[13:9] == ENC_ADD_L) o = OP_ADD_LIT;
    else if (w[13:8] == ENC_AND_L) o = OP_AND_LIT;
    else if (w[13:8] == ENC_OR_L) o = OP_OR_LIT;
    else if (w[13:8] == ENC_ADD_F) o = OP_ADD_FILE;
    else if (w[13:8] == ENC_AND_F) o = OP_AND_FILE;
    else if (w[13:8] == ENC_OR_F) o = OP_OR_FILE;
    else if (w[13:8] == ENC_COMP_F) o = OP_COMP;
    else if (w[13:8] == ENC_CLR) o = w[7] ? OP_CLR_FILE : OP_CLR_W;
    else if (w[13:8] == ENC_DEC_F) o = OP_DEC;
    else if (w[13:8] == ENC_INC_F) o = OP_INC;
    else if (w[13:8] == ENC_DEC_SK) o = OP_DEC_SKIP;
    else if (w[13:8] == ENC_INC_SK) o = OP_INC_SKIP;
    return o;
  endfunction : cie_decode

endpackage : cie_pkg
`default_nettype wire

// ===== cie_core.sv
// Summary of operation
// - File operations send the result to W when d is 0, else back to file.
// - Add W to the addressed file, updating carry, half carry and zero.
// - AND W with the file, route by d, update zero only.
// - OR W with the file, route by d, update zero only.
// - AND W with an 8-bit literal into W, update zero only.
// - OR W with an 8-bit literal into W, update zero only.
// - Set one selected bit of the file, nothing else changes.
// - Test bit; if clear, replace the next instruction with a NOP.
// - Test bit; if set, replace the next instruction with a NOP.
// - Watchdog clear zeroes counter and prescaler, sets both status flags.
// - Call pushes PC+1, loads 11-bit target plus page bits, two cycles.
// - Branch loads 11-bit target plus page bits, no push, two cycles.
// - Complement the file, route by d, update zero only.
// - Clear the file to zero and set the zero flag.
// - Clear W to zero and set the zero flag, other flags kept.
// - Decrement or increment the file, route by d, update zero only.
// - Decrement, route by d; zero result skips next instruction, no flags. The code writes the result nowhere when d is 0.
// - Increment, route by d; zero result skips next instruction, no flags. The code writes the result nowhere when d is 0.
// - One instruction cycle lasts four core clocks.
// - Add an 8-bit literal to W, updating carry, half carry and zero.
//
// Register access over APB and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module cie_core (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // Register bus
  input  wire cie_pkg::cie_apb_req_t apb_req,
  output      cie_pkg::cie_apb_rsp_t apb_rsp,
  // Program memory
  output      logic [12:0]       prog_addr,
  input  wire logic [13:0]       prog_data,
  // Data register file
  output      cie_pkg::cie_file_req_t file_req,
  input  wire logic [7:0]        file_rdata,
  // Instruction cycle marker
  output      logic              cycle_end
);
  import cie_pkg::*;

  // ==========================================================================
  // State
  // ==========================================================================
  cie_state_t  s_ff;
  cie_state_t  nxt_s;
  cie_op_t     op;
  logic        exec_now;
  logic        wr_file;
  logic        upd_z;
  logic        skip;
  logic [7:0]  opnd;
  logic [8:0]  sum9;
  logic [4:0]  half5;
  logic [7:0]  res;
  logic [7:0]  bit_mask;
  logic [10:0] k11;
  logic [12:0] target;

  // ==========================================================================
  // Outputs
  // ==========================================================================
  // Zero-wait slave: read data is captured in the setup cycle.
  assign apb_rsp.prdata   = s_ff.prdata;
  assign apb_rsp.pready   = 1'b1;
  assign apb_rsp.pslverr  = s_ff.pslverr;
  assign prog_addr        = s_ff.pc;
  assign file_req.addr    = s_ff.inst[6:0];
  assign file_req.we      = s_ff.file_we;
  assign file_req.wdata   = s_ff.file_wdata;
  assign cycle_end        = s_ff.run && (s_ff.phase == PH_WRITE);

  // ==========================================================================
  // Datapath
  // ==========================================================================
  // The file operand is read live in the execute phase; the register file
  // sits on this clock, so no synchroniser is wanted on file_rdata.
  always_comb begin
    op       = cie_decode(s_ff.inst);
    exec_now = s_ff.run && (s_ff.phase == PH_EXEC) && !s_ff.discard &&
               !s_ff.hold;
    k11      = s_ff.inst[10:0];
    target   = {s_ff.page[4:3], k11};
    bit_mask = 8'h01 << s_ff.inst[9:7];
    opnd     = (op == OP_ADD_LIT) ? s_ff.inst[7:0] : file_rdata;
    sum9     = {1'b0, s_ff.wreg} + {1'b0, opnd};
    half5    = {1'b0, s_ff.wreg[3:0]} + {1'b0, opnd[3:0]};
    res      = 8'h00;
    wr_file  = 1'b0;
    upd_z    = 1'b0;
    skip     = 1'b0;
    unique case (op)
      OP_ADD_FILE, OP_ADD_LIT: begin
        res   = sum9[7:0];
        upd_z = 1'b1;
      end
      OP_AND_FILE: begin
        res   = s_ff.wreg & file_rdata;
        upd_z = 1'b1;
      end
      OP_OR_FILE: begin
        res   = s_ff.wreg | file_rdata;
        upd_z = 1'b1;
      end
      OP_AND_LIT: begin
        res   = s_ff.wreg & s_ff.inst[7:0];
        upd_z = 1'b1;
      end
      OP_OR_LIT: begin
        res   = s_ff.wreg | s_ff.inst[7:0];
        upd_z = 1'b1;
      end
      OP_COMP: begin
        res   = ~file_rdata;
        upd_z = 1'b1;
      end
      OP_DEC, OP_DEC_SKIP: begin
        res   = file_rdata - 8'h01;
        upd_z = (op == OP_DEC);
        skip  = (op == OP_DEC_SKIP) && (res == 8'h00);
      end
      OP_INC, OP_INC_SKIP: begin
        res   = file_rdata + 8'h01;
        upd_z = (op == OP_INC);
        skip  = (op == OP_INC_SKIP) && (res == 8'h00);
      end
      OP_CLR_FILE, OP_CLR_W: begin
        res   = 8'h00;
        upd_z = 1'b1;
      end
      OP_BIT_SET: begin
        res     = file_rdata | bit_mask;
        wr_file = 1'b1;
      end
      OP_SKIP_CLR: skip = ((file_rdata & bit_mask) == 8'h00);
      OP_SKIP_SET: skip = ((file_rdata & bit_mask) != 8'h00);
      OP_NOP, OP_CALL, OP_BRANCH, OP_WDT_CLR: res = 8'h00;
    endcase
    // Byte operations honour the destination bit; clear-file always writes.
    if (op inside {OP_ADD_FILE, OP_AND_FILE, OP_OR_FILE, OP_COMP, OP_DEC,
                   OP_INC, OP_DEC_SKIP, OP_INC_SKIP})
      wr_file = s_ff.inst[7];
    if (op == OP_CLR_FILE)
      wr_file = 1'b1;
  end

  // ==========================================================================
  // Next state: bus access first, core second, so hardware wins a collision
  // ==========================================================================
  always_comb begin
    nxt_s         = s_ff;
    nxt_s.file_we = 1'b0;
    // APB setup cycle: capture read data and the error answer.
    if (apb_req.psel && !apb_req.penable) begin
      nxt_s.pslverr = 1'b0;
      nxt_s.prdata  = 32'h0000_0000;
      unique case (apb_req.paddr)
        REG_CTRL:   nxt_s.prdata[CTRL_RUN] = s_ff.run;
        REG_WORK:   nxt_s.prdata[7:0] = s_ff.wreg;
        REG_STATUS: begin
          nxt_s.prdata[ST_C]   = s_ff.carry;
          nxt_s.prdata[ST_HC]  = s_ff.half_carry;
          nxt_s.prdata[ST_Z]   = s_ff.zero;
          nxt_s.prdata[ST_PDN] = s_ff.pdown_flag;
          nxt_s.prdata[ST_TMO] = s_ff.timeout_flag;
        end
        REG_PC:     nxt_s.prdata[12:0] = s_ff.pc;
        REG_PAGE:   nxt_s.prdata[7:0] = s_ff.page;
        REG_WDT:    nxt_s.prdata[7:0] = s_ff.wdt_cnt;
        default:    nxt_s.pslverr = 1'b1;
      endcase
    end
    // APB access cycle: writes land here; PC and WDT are read only.
    if (apb_req.psel && apb_req.penable && apb_req.pwrite) begin
      unique case (apb_req.paddr)
        REG_CTRL:   nxt_s.run = apb_req.pwdata[CTRL_RUN];
        REG_WORK:   nxt_s.wreg = apb_req.pwdata[7:0];
        REG_STATUS: begin
          nxt_s.carry        = apb_req.pwdata[ST_C];
          nxt_s.half_carry   = apb_req.pwdata[ST_HC];
          nxt_s.zero         = apb_req.pwdata[ST_Z];
          nxt_s.pdown_flag   = apb_req.pwdata[ST_PDN];
          nxt_s.timeout_flag = apb_req.pwdata[ST_TMO];
        end
        REG_PAGE:   nxt_s.page = apb_req.pwdata[7:0];
        default:    nxt_s.pslverr = s_ff.pslverr;
      endcase
    end
    // Phase sequencer: four clocks per instruction cycle, frozen when halted.
    if (s_ff.run) begin
      nxt_s.phase = cie_phase_t'(s_ff.phase + 2'b01);
      if (s_ff.phase == PH_LATCH)
        nxt_s.inst = prog_data;
      // Watchdog prescaler ticks once per instruction cycle.
      if (s_ff.phase == PH_WRITE) begin
        nxt_s.wdt_pre = s_ff.wdt_pre + 8'h01;
        if (s_ff.wdt_pre == 8'hFF) begin
          nxt_s.wdt_cnt = s_ff.wdt_cnt + 8'h01;
          if (s_ff.wdt_cnt == 8'hFF)
            nxt_s.timeout_flag = 1'b0;
        end
      end
    end
    // The cycle after a skip runs as a NOP and moves on.
    if (s_ff.run && s_ff.phase == PH_EXEC && s_ff.discard) begin
      nxt_s.discard = 1'b0;
      nxt_s.pc      = s_ff.pc + 13'h0001;
    end
    // The cycle after a branch runs as a NOP and refetches the target.
    if (s_ff.run && s_ff.phase == PH_EXEC && s_ff.hold)
      nxt_s.hold = 1'b0;
    if (exec_now) begin
      nxt_s.pc = s_ff.pc + 13'h0001;
      if (wr_file) begin
        nxt_s.file_we    = 1'b1;
        nxt_s.file_wdata = res;
      end else if (upd_z) begin
        nxt_s.wreg = res;
      end
      if (upd_z)
        nxt_s.zero = (res == 8'h00);
      if (op == OP_ADD_FILE || op == OP_ADD_LIT) begin
        nxt_s.carry      = sum9[8];
        nxt_s.half_carry = half5[4];
      end
      if (skip)
        nxt_s.discard = 1'b1;
      if (op == OP_CALL) begin
        nxt_s.stack[s_ff.sp] = s_ff.pc + 13'h0001;
        nxt_s.sp             = s_ff.sp + 1'b1;
      end
      if (op == OP_CALL || op == OP_BRANCH) begin
        nxt_s.pc   = target;
        nxt_s.hold = 1'b1;
      end
      if (op == OP_WDT_CLR) begin
        nxt_s.wdt_cnt      = 8'h00;
        nxt_s.wdt_pre      = 8'h00;
        nxt_s.timeout_flag = 1'b1;
        nxt_s.pdown_flag   = 1'b1;
      end
    end
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  always_ff @(posedge clk) begin
    if (rst) begin
      s_ff              <= '0;
      s_ff.run          <= RST_RUN;
      s_ff.phase        <= PH_ADDR;
      s_ff.timeout_flag <= RST_STFLAG;
      s_ff.pdown_flag   <= RST_STFLAG;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  phase_step_a: assert property (
    s_ff.run && s_ff.phase == PH_EXEC && !$past(rst)
    |-> $past(s_ff.phase, 2) == PH_ADDR || !$past(s_ff.run, 2))
    else $error("phase order broken");
  cycle_len_a: assert property (
    cycle_end && $past(s_ff.run, 4) && s_ff.run
    |-> $past(cycle_end, 4))
    else $error("instruction cycle is not four clocks");
  dest_route_a: assert property (
    exec_now && op inside {OP_AND_FILE, OP_OR_FILE, OP_COMP}
    |=> file_req.we == $past(s_ff.inst[7]))
    else $error("destination bit not honoured");
  add_sum_a: assert property (
    exec_now && op == OP_ADD_FILE && !s_ff.inst[7]
    |=> s_ff.wreg == $past(s_ff.wreg) + $past(file_rdata) &&
        s_ff.carry == ($past({1'b0, s_ff.wreg}) + $past({1'b0, file_rdata})
                       > 9'h0FF))
    else $error("add result or carry wrong");
  zero_flag_a: assert property (
    exec_now && op inside {OP_AND_LIT, OP_OR_LIT} && !apb_req.psel
    |=> s_ff.zero == (s_ff.wreg == 8'h00))
    else $error("zero flag does not match result");
  bit_set_a: assert property (
    exec_now && op == OP_BIT_SET
    |=> file_req.we && file_req.wdata ==
        ($past(file_rdata) | (8'h01 << $past(s_ff.inst[9:7]))) &&
        $stable(s_ff.zero))
    else $error("bit set wrong");
  skip_nop_a: assert property (
    exec_now && skip |=> !exec_now [*4])
    else $error("skipped instruction executed");
  call_push_a: assert property (
    exec_now && op == OP_CALL
    |=> s_ff.pc == $past(target) &&
        s_ff.stack[$past(s_ff.sp)] == $past(s_ff.pc) + 13'h0001)
    else $error("call target or return address wrong");
  branch_a: assert property (
    exec_now && op == OP_BRANCH
    |=> s_ff.pc == $past(target) && s_ff.sp == $past(s_ff.sp) ##4 !exec_now)
    else $error("branch wrong");
  wdt_clear_a: assert property (
    exec_now && op == OP_WDT_CLR
    |=> s_ff.wdt_cnt == 8'h00 && s_ff.timeout_flag && s_ff.pdown_flag)
    else $error("watchdog clear wrong");
  clear_w_a: assert property (
    exec_now && op == OP_CLR_W && !apb_req.psel
    |=> s_ff.wreg == 8'h00 && s_ff.zero && $stable(s_ff.carry))
    else $error("clear working wrong");

  call_seen_c:   cover property (exec_now && op == OP_CALL);
  skip_seen_c:   cover property (exec_now && skip);
  branch_seen_c: cover property (exec_now && op == OP_BRANCH);
  wdt_seen_c:    cover property (exec_now && op == OP_WDT_CLR);

endmodule : cie_core
`default_nettype wire

// ===== cie_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module cie_mem_model (
  // Clock
  input  wire logic                   clk,
  // Program memory side
  input  wire logic [12:0]            prog_addr,
  output      logic [13:0]            prog_data,
  // Data register file side
  input  wire cie_pkg::cie_file_req_t file_req,
  output      logic [7:0]             file_rdata
);
  import cie_pkg::*;

  logic [13:0] rom [8192];
  logic [7:0]  ram [128];

  // Both memories answer in the same clock; the core samples late in a phase.
  assign prog_data  = rom[prog_addr];
  assign file_rdata = ram[file_req.addr];

  // Writes land only on the strobe, so a discarded instruction leaves no trace.
  always @(posedge clk) begin
    if (file_req.we === 1'b1) begin
      ram[file_req.addr] <= file_req.wdata;
    end
  end
endmodule : cie_mem_model
`default_nettype wire

// ===== cpu_instruction_execute_tb.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_instruction_execute_tb;
  import cie_pkg::*;

  logic          clk;
  logic          rst;
  cie_apb_req_t  req;
  cie_apb_rsp_t  rsp;
  logic [12:0]   prog_addr;
  logic [13:0]   prog_data;
  cie_file_req_t file_req;
  logic [7:0]    file_rdata;
  logic          cycle_end;
  int            failures;
  int            checks_done;
  int            ticks;
  logic [31:0]   q;
  logic          err;

  cie_core u_cie_core (.clk(clk), .rst(rst), .apb_req(req), .apb_rsp(rsp),
    .prog_addr(prog_addr), .prog_data(prog_data), .file_req(file_req),
    .file_rdata(file_rdata), .cycle_end(cycle_end));
  cie_mem_model u_cie_mem_model (.clk(clk), .prog_addr(prog_addr),
    .prog_data(prog_data), .file_req(file_req), .file_rdata(file_rdata));

  // ==========================================================================
  // Clock, watchdog of the run and helpers
  // ==========================================================================
  // The 100 MHz core clock.
  always #5 clk = ~clk;

  // A hung wait ends the run here rather than stalling the simulator.
  always @(posedge clk) begin
    ticks <= ticks + 1;
    if (ticks == 6000) begin
      failures++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run

  task automatic chk(logic [31:0] got, logic [31:0] exp, string what);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got,
               exp);
    end
  endtask : chk

  // Encoders for the instruction shapes.
  function automatic logic [13:0] fo(logic [5:0] e, logic d, logic [6:0] f);
    return {e, d, f};
  endfunction : fo
  function automatic logic [13:0] bo(logic [3:0] e, logic [2:0] b,
                                     logic [6:0] f);
    return {e, b, f};
  endfunction : bo
  function automatic logic [13:0] lo(logic [5:0] e, logic [7:0] k);
    return {e, k};
  endfunction : lo
  function automatic logic [13:0] jo(logic [2:0] e, logic [10:0] k);
    return {e, k};
  endfunction : jo

  task automatic ld(int a, logic [13:0] w);
    u_cie_mem_model.rom[a] = w;
  endtask : ld
  task automatic sf(int a, logic [7:0] v);
    u_cie_mem_model.ram[a] = v;
  endtask : sf
  function automatic logic [7:0] rf(int a);
    return u_cie_mem_model.ram[a];
  endfunction : rf

  // One APB transfer; the request holds until pready is seen at an edge.
  task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    req <= '{1'b1, 1'b0, wr, a, d};
    @(posedge clk);
    req.penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (rsp.pready !== 1'b1 && k < 20);
    q   = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
    chk({31'h0, rsp.pready}, 32'h1, "pready");
  endtask : apb

  // Reset wipes the core and the program store, not the data file.
  task automatic reset_core();
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 8192; i++) begin
      ld(i, 14'h0000);
    end
  endtask : reset_core

  // Runs until an instruction cycle ends with the program counter at a.
  task automatic run_to(logic [12:0] a, int exp_n);
    int n;
    int gap;
    n = 0;
    gap = -1;
    apb(1'b1, REG_CTRL, 32'h1);
    do begin
      @(negedge clk);
      if (gap >= 0) begin
        gap++;
      end
      if (cycle_end === 1'b1) begin
        if (gap >= 0) chk(gap, CYCLE_CLKS, "clocks per cycle");
        gap = 0;
        n++;
      end
    end while (!(cycle_end === 1'b1 && prog_addr === a) && n < 60);
    apb(1'b1, REG_CTRL, 32'h0);
    chk(n, exp_n, "instruction cycles");
  endtask : run_to

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_regs();
    reset_core();
    apb(1'b0, REG_STATUS, 32'h0);
    chk(q, 32'h18, "status after reset");
    apb(1'b1, REG_PC, 32'h55);
    apb(1'b0, REG_PC, 32'h0);
    chk(q, 32'h0, "counter is read only");
    apb(1'b0, 8'h40, 32'h0);
    chk({31'h0, err}, 32'h1, "unmapped error");
    apb(1'b1, REG_WORK, 32'hA5);
    apb(1'b0, REG_WORK, 32'h0);
    chk(q, 32'hA5, "working register");
    $display("test registers done");
  endtask : t_regs

  task automatic t_file_ops();
    reset_core();
    sf(10, 8'h0F);
    sf(11, 8'hF1);
    sf(12, 8'hF1);
    ld(0, fo(ENC_ADD_F, 1'b1, 7'd10));
    ld(1, fo(ENC_AND_F, 1'b0, 7'd11));
    ld(2, fo(ENC_OR_F, 1'b0, 7'd10));
    ld(3, fo(ENC_COMP_F, 1'b1, 7'd11));
    ld(4, fo(ENC_INC_F, 1'b0, 7'd11));
    ld(5, fo(ENC_DEC_F, 1'b1, 7'd10));
    ld(6, fo(ENC_ADD_F, 1'b0, 7'd12));
    ld(7, fo(ENC_DEC_F, 1'b0, 7'd10));
    ld(8, jo(ENC_BRANCH, 11'd8));
    apb(1'b1, REG_WORK, 32'h01);
    run_to(13'd8, 8);
    apb(1'b0, REG_WORK, 32'h0);
    chk(q, 32'h0E, "working result");
    apb(1'b0, REG_STATUS, 32'h0);
    chk(q, 32'h1B, "add flags kept");
    chk(rf(10), 8'h0F, "file 10");
    chk(rf(11), 8'h0E, "file 11");
    $display("test file operations done");
  endtask : t_file_ops

  task automatic t_literals();
    reset_core();
    sf(20, 8'h77);
    ld(0, lo(ENC_AND_L, 8'hF0));
    ld(1, lo(ENC_OR_L, 8'h05));
    ld(2, lo({ENC_ADD_L, 1'b0}, 8'hCB));
    ld(3, lo(ENC_OR_L, 8'h80));
    ld(4, fo(ENC_CLR, 1'b0, 7'd0));
    ld(5, lo(ENC_OR_L, 8'h01));
    ld(6, fo(ENC_CLR, 1'b1, 7'd20));
    ld(7, jo(ENC_BRANCH, 11'd7));
    apb(1'b1, REG_WORK, 32'h3C);
    run_to(13'd7, 7);
    apb(1'b0, REG_WORK, 32'h0);
    chk(q, 32'h01, "literal chain");
    apb(1'b0, REG_STATUS, 32'h0);
    chk(q, 32'h1F, "literal flags");
    chk(rf(20), 8'h00, "cleared file");
    $display("test literals done");
  endtask : t_literals

  task automatic t_skips();
    reset_core();
    sf(30, 8'h00);
    sf(31, 8'h01);
    sf(32, 8'hFF);
    ld(0, bo(ENC_BIT_SET, 3'd6, 7'd30));
    ld(1, bo(ENC_SK_CLR, 3'd6, 7'd30));
    ld(2, lo(ENC_OR_L, 8'h01));
    ld(3, bo(ENC_SK_CLR, 3'd0, 7'd30));
    ld(4, lo(ENC_OR_L, 8'h02));
    ld(5, bo(ENC_SK_SET, 3'd6, 7'd30));
    ld(6, lo(ENC_OR_L, 8'h04));
    ld(7, bo(ENC_SK_SET, 3'd0, 7'd30));
    ld(8, lo(ENC_OR_L, 8'h08));
    ld(9, fo(ENC_DEC_SK, 1'b1, 7'd31));
    ld(10, lo(ENC_OR_L, 8'h10));
    ld(11, fo(ENC_INC_SK, 1'b1, 7'd32));
    ld(12, lo(ENC_OR_L, 8'h20));
    ld(13, fo(ENC_INC_SK, 1'b1, 7'd30));
    ld(14, jo(ENC_BRANCH, 11'd14));
    run_to(13'd14, 14);
    apb(1'b0, REG_WORK, 32'h0);
    chk(q, 32'h09, "skipped words");
    apb(1'b0, REG_STATUS, 32'h0);
    chk(q, 32'h18, "skip flags");
    chk(rf(30), 8'h41, "bit set");
    chk(rf(31), 8'h00, "decrement skip");
    chk(rf(32), 8'h00, "increment skip");
    $display("test skips done");
  endtask : t_skips

  task automatic t_flow();
    reset_core();
    apb(1'b1, REG_STATUS, 32'h0);
    apb(1'b1, REG_PAGE, 32'h08);
    ld(0, ENC_WDT_CLR);
    ld(1, jo(ENC_CALL, 11'h010));
    ld(13'h810, jo(ENC_BRANCH, 11'h020));
    ld(13'h820, jo(ENC_BRANCH, 11'h020));
    run_to(13'h820, 4);
    apb(1'b0, REG_STATUS, 32'h0);
    chk(q, 32'h18, "watchdog flags");
    apb(1'b0, REG_WDT, 32'h0);
    chk(q, 32'h0, "watchdog count");
    apb(1'b0, REG_PC, 32'h0);
    chk(q, 32'h820, "paged target");
    $display("test flow done");
  endtask : t_flow

  // Main sequence: long reset, then every scenario in turn.
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    req = '0;
    failures = 0;
    checks_done = 0;
    ticks = 0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_file_ops();
    t_literals();
    t_skips();
    t_flow();
    complete_run();
  end
endmodule : cpu_instruction_execute_tb
`default_nettype wire
